//--- isa_link_params.svh
// Purpose: Constants shared by both ends of the ISA host bus link.
// Assumes: 100 MHz mclk; all link pins are synchronous to mclk.
// Notes: Offsets, field positions, reset values and timing counts.
`ifndef ISA_LINK_PARAMS_SVH
`define ISA_LINK_PARAMS_SVH

`define ISA_ADDR_W 11
`define ISA_DMA_CHANNELS 3
`define ISA_IRQ_PINS 5
`define ISA_ROUTE_NONE 3'h7
`define FUNC_REG_RESET 8'h00
`define BUS_IDLE_DATA 8'hFF

// ************************************************************
// Timing
// ************************************************************
`define CLK_PERIOD_NS 10
`define HW_RESET_MIN_NS 500
`define RESET_HOLD_CYC ((`HW_RESET_MIN_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define IRQ_PULSE_NS 100
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define SETUP_CYC 1
`define STROBE_CYC 4

// ************************************************************
// Controller registers (byte addresses)
// ************************************************************
`define REG_CMD 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0C
`define REG_STATUS 8'h10
`define REG_ISTAT 8'h14
`define REG_IMASK 8'h18
`define REG_PINS 8'h1C
`define CMD_GO 0
`define CMD_READ 1
`define CMD_DMA 2
`define CMD_CHAN_LSB 3
`define CMD_TC 5
`define ADDR_AEN 11
`define PINS_QUALIFY 0
`define PINS_RESET 1
`define IST_DONE 0
`define IST_DRQ 1
`define PINS_RESET_VAL 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- isa_link_pkg.sv
// Purpose: Types shared by both ends of the ISA host bus link.
// Assumes: isa_link_params.svh supplies the widths.
// Notes: No constants here beyond types.
`include "isa_link_params.svh"
package isa_link_pkg;
  typedef logic [`ISA_ADDR_W-1:0] addr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {TC_HIGH_AT, TC_HIGH_M30, TC_LOW_ALT} tc_mode_e;
  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_RECOVER} host_state_e;
endpackage

//--- isa_link_if.sv
// Purpose: Pin-level link between the controller and the device end.
// Assumes: Pull-ups on the data bus and on released interrupt lines.
// Notes: Resolves two-way data and open-drain lines from the enables.
`timescale 1ns/100ps
interface isa_link_if;
  import isa_link_pkg::*;
  logic iorN;
  logic iowN;
  logic aen;
  addr_t addr;
  logic tc;
  logic upperAddressQualifyN;
  logic hwReset;
  logic [`ISA_DMA_CHANNELS-1:0] dmaAckN;
  logic [`ISA_DMA_CHANNELS-1:0] dmaRequest;
  byte_t hostData;
  logic hostDataOe;
  byte_t devData;
  logic devDataOe;
  byte_t dataBus;
  logic [`ISA_IRQ_PINS-1:0] irqOut;
  logic [`ISA_IRQ_PINS-1:0] irqOe;
  logic [`ISA_IRQ_PINS-1:0] irqLine;

  assign dataBus = devDataOe ? devData :
                   (hostDataOe ? hostData : `BUS_IDLE_DATA);
  assign irqLine = (irqOe & irqOut) | ~irqOe;

  modport device(input iorN, input iowN, input aen, input addr, input tc,
    input upperAddressQualifyN, input hwReset, input dmaAckN,
    input dataBus, output devData, output devDataOe, output dmaRequest,
    output irqOut, output irqOe);
  modport host(output iorN, output iowN, output aen, output addr,
    output tc, output upperAddressQualifyN, output hwReset,
    output dmaAckN, output hostData, output hostDataOe,
    input dataBus, input dmaRequest, input irqLine);
endinterface

//--- isa_device_end.sv
// Purpose: Device end of the ISA link: decode, registers, DMA, interrupts.
// Assumes: Link pins synchronous to mclk; configuration held outside.
// Notes: Functional registers sit at baseAddr .. baseAddr+RegCount-1.
`timescale 1ns/100ps
module isa_device_end #(
  parameter int RegCount = 8,
  parameter int SrcCount = 3,
  parameter int PulseCycles = `IRQ_PULSE_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  isa_link_if.device link,
  input wire isa_link_pkg::addr_t baseAddr,
  input wire logic qualifyEnable,
  input wire isa_link_pkg::tc_mode_e tcMode,
  input wire logic pulsedIrqMode,
  input wire logic [1:0] dmaChannel,
  input wire logic dmaStart,
  input wire logic [15:0] dmaLength,
  input wire logic [SrcCount-1:0] funcIrq,
  input wire logic externalInterruptInput,
  input wire logic [3*SrcCount+2:0] irqRoute,
  output logic [8*RegCount-1:0] regImage,
  output isa_link_pkg::byte_t writeData,
  output logic writeStb,
  output logic writeFromDma,
  output logic dmaBusy,
  output logic tcSeen,
  output logic functionalReset
);
  import isa_link_pkg::*;

  localparam int Pins = `ISA_IRQ_PINS;
  localparam int CntW = $clog2(PulseCycles + 1);

  if (RegCount < 1 || RegCount > 256) begin : g_badRegs
    $error("RegCount out of range");
  end
  if (SrcCount < 1 || PulseCycles < 1) begin : g_badIrq
    $error("SrcCount and PulseCycles must be positive");
  end

  // ************************************************************
  // Strobe edges and address latch
  // ************************************************************
  logic iorPrevQ;
  logic iowPrevQ;
  logic ackPrevQ;
  logic iorFall;
  logic iorRise;
  logic iowFall;
  logic iowRise;
  logic ackLow;
  logic ackFall;
  logic ioHitNow;
  addr_t offsetNow;
  addr_t offsetQ;
  logic readSelQ;
  logic writeSelQ;
  logic dmaCycQ;
  logic [1:0] chanQ;
  logic drqQ;
  logic [15:0] remainQ;
  logic tcAccepted;
  logic tcLevel;
  logic hwRst;
  byte_t regFile [RegCount];

  assign hwRst = link.hwReset;
  assign iorFall = iorPrevQ & ~link.iorN;
  assign iorRise = ~iorPrevQ & link.iorN;
  assign iowFall = iowPrevQ & ~link.iowN;
  assign iowRise = ~iowPrevQ & link.iowN;
  assign ackLow = ~link.dmaAckN[chanQ] & drqOrBusy();
  assign ackFall = ackLow & ~ackPrevQ;

  function automatic logic drqOrBusy();
    return drqQ | (remainQ != 16'h0000);
  endfunction

  // Full-width subtraction keeps every address bit in the compare
  assign offsetNow = link.addr - baseAddr;
  assign ioHitNow = ~link.aen
    & (~qualifyEnable | ~link.upperAddressQualifyN)
    & (offsetNow < addr_t'(RegCount))
    & ~ackLow;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      iorPrevQ <= 1'b1;
      iowPrevQ <= 1'b1;
      ackPrevQ <= 1'b0;
    end else begin
      iorPrevQ <= link.iorN;
      iowPrevQ <= link.iowN;
      ackPrevQ <= ackLow;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      offsetQ <= '0;
      readSelQ <= 1'b0;
      writeSelQ <= 1'b0;
      dmaCycQ <= 1'b0;
    end else if (hwRst) begin
      readSelQ <= 1'b0;
      writeSelQ <= 1'b0;
      dmaCycQ <= 1'b0;
    end else begin
      if (iorFall | iowFall) begin
        offsetQ <= offsetNow;
        dmaCycQ <= ackLow;
      end
      if (iorFall) begin
        readSelQ <= ioHitNow | ackLow;
      end else if (iorRise) begin
        readSelQ <= 1'b0;
      end
      if (iowFall) begin
        writeSelQ <= ioHitNow | ackLow;
      end else if (iowRise) begin
        writeSelQ <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Functional registers and read data
  // ************************************************************
  // DMA bytes always use register 0, the data port
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < RegCount; i++) begin
        regFile[i] <= `FUNC_REG_RESET;
      end
      writeData <= `FUNC_REG_RESET;
      writeStb <= 1'b0;
      writeFromDma <= 1'b0;
    end else if (hwRst) begin
      for (int i = 0; i < RegCount; i++) begin
        regFile[i] <= `FUNC_REG_RESET;
      end
      writeStb <= 1'b0;
    end else begin
      writeStb <= iowRise & writeSelQ;
      if (iowRise && writeSelQ) begin
        regFile[dmaCycQ ? 0 : int'(offsetQ)] <= link.dataBus;
        writeData <= link.dataBus;
        writeFromDma <= dmaCycQ;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      link.devData <= `FUNC_REG_RESET;
    end else if (iorFall) begin
      link.devData <= ackLow ? regFile[0] : regFile[int'(offsetNow)];
    end
  end

  // Bus is released the moment the read strobe rises
  assign link.devDataOe = readSelQ & ~link.iorN;

  for (genvar r = 0; r < RegCount; r++) begin : g_image
    assign regImage[8*r +: 8] = regFile[r];
  end

  // ************************************************************
  // DMA request, byte count and terminal count
  // ************************************************************
  assign tcLevel = (tcMode == TC_LOW_ALT) ? ~link.tc : link.tc;
  assign tcAccepted = tcLevel & ackLow;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drqQ <= 1'b0;
      chanQ <= 2'h0;
      remainQ <= 16'h0000;
      tcSeen <= 1'b0;
    end else if (hwRst) begin
      drqQ <= 1'b0;
      remainQ <= 16'h0000;
      tcSeen <= 1'b0;
    end else if (dmaStart && !drqOrBusy()) begin
      drqQ <= (dmaLength != 16'h0000);
      chanQ <= dmaChannel;
      remainQ <= dmaLength;
      tcSeen <= 1'b0;
    end else if (tcAccepted) begin
      drqQ <= 1'b0;
      remainQ <= 16'h0000;
      tcSeen <= 1'b1;
    end else begin
      if (ackLow && (iorFall || iowFall) && remainQ != 16'h0000) begin
        remainQ <= remainQ - 16'h0001;
      end
      // Request holds until the final byte is reached
      if (remainQ == 16'h0001) begin
        if (ackFall) begin
          drqQ <= 1'b0;
        end else if (ackPrevQ && ackLow && (iorFall || iowFall)) begin
          drqQ <= 1'b0;
        end
      end
    end
  end

  for (genvar c = 0; c < `ISA_DMA_CHANNELS; c++) begin : g_drq
    assign link.dmaRequest[c] = drqQ & (chanQ == 2'(c));
  end
  assign dmaBusy = remainQ != 16'h0000;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      functionalReset <= 1'b0;
    end else begin
      functionalReset <= hwRst;
    end
  end

  // ************************************************************
  // Interrupt routing and pulsed sharing
  // ************************************************************
  logic [SrcCount:0] allSrc;
  logic [Pins-1:0] pinReq;

  assign allSrc = {externalInterruptInput, funcIrq};

  always_comb begin
    pinReq = '0;
    for (int s = 0; s <= SrcCount; s++) begin
      for (int p = 0; p < Pins; p++) begin
        if (irqRoute[3*s +: 3] == 3'(p) && allSrc[s]) begin
          pinReq[p] = 1'b1;
        end
      end
    end
  end

  for (genvar p = 0; p < Pins; p++) begin : g_irq
    logic levelQ;
    logic [CntW-1:0] pulseQ;
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        levelQ <= 1'b0;
        pulseQ <= '0;
      end else if (hwRst) begin
        levelQ <= 1'b0;
        pulseQ <= '0;
      end else begin
        levelQ <= pinReq[p];
        if (pulsedIrqMode && pinReq[p] && !levelQ) begin
          pulseQ <= CntW'(PulseCycles);
        end else if (pulseQ != '0) begin
          pulseQ <= pulseQ - 1'b1;
        end
      end
    end
    // Shared mode drives only the low pulse; the line floats otherwise
    assign link.irqOut[p] = pulsedIrqMode ? 1'b0 : levelQ;
    assign link.irqOe[p] = pulsedIrqMode ? (pulseQ != '0) : 1'b1;
  end
endmodule

//--- isa_host_end.sv
// Purpose: Controller end: runs ISA I/O and DMA cycles from AXI4-Lite.
// Assumes: One cycle in flight; software polls or takes the interrupt.
// Notes: Hardware reset pin is stretched to its least hold time.
`timescale 1ns/100ps
module isa_host_end (
  input wire logic mclk,
  input wire logic nrst,
  isa_link_if.host link,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);
  import isa_link_pkg::*;

  // ************************************************************
  // Register slave
  // ************************************************************
  logic wrGo;
  logic [31:0] wMask;
  logic [31:0] wVal;
  logic [5:0] cmdQ;
  logic [11:0] addrQ;
  byte_t wdataQ;
  byte_t rdataQ;
  logic [1:0] pinsQ;
  logic [1:0] istatQ;
  logic [1:0] imaskQ;
  logic [1:0] istatSet;
  logic [`ISA_DMA_CHANNELS-1:0] drqPrevQ;
  logic [31:0] rdMux;
  logic rdOk;
  logic wrOk;
  host_state_e stateQ;
  logic [2:0] cntQ;

  assign wrGo = awvalid & wvalid & ~bvalid;
  assign awready = wrGo;
  assign wready = wrGo;
  assign arready = ~rvalid;
  assign wMask = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  assign wVal = wdata & wMask;
  assign wrOk = awaddr[1:0] == 2'h0 && awaddr <= `REG_PINS;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else if (wrGo) begin
      bvalid <= 1'b1;
      bresp <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Writes while a cycle runs leave the command fields alone
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmdQ <= '0;
      addrQ <= '0;
      wdataQ <= 8'h00;
      pinsQ <= `PINS_RESET_VAL;
      imaskQ <= 2'h0;
    end else if (wrGo && stateQ == S_IDLE) begin
      case (awaddr)
        `REG_CMD: cmdQ <= (cmdQ & ~wMask[5:0]) | wVal[5:0];
        `REG_ADDR: addrQ <= (addrQ & ~wMask[11:0]) | wVal[11:0];
        `REG_WDATA: wdataQ <= (wdataQ & ~wMask[7:0]) | wVal[7:0];
        `REG_PINS: pinsQ <= (pinsQ & ~wMask[1:0]) | wVal[1:0];
        `REG_IMASK: imaskQ <= (imaskQ & ~wMask[1:0]) | wVal[1:0];
        default: ;
      endcase
    end else if (wrGo && awaddr == `REG_IMASK) begin
      imaskQ <= (imaskQ & ~wMask[1:0]) | wVal[1:0];
    end else if (stateQ == S_RECOVER) begin
      cmdQ[`CMD_GO] <= 1'b0;
    end
  end

  // Set wins over a same-cycle write-one clear
  assign istatSet[`IST_DONE] = (stateQ == S_RECOVER);
  assign istatSet[`IST_DRQ] = |(link.dmaRequest & ~drqPrevQ);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      istatQ <= 2'h0;
      drqPrevQ <= '0;
    end else begin
      drqPrevQ <= link.dmaRequest;
      if (wrGo && awaddr == `REG_ISTAT) begin
        istatQ <= (istatQ & ~wVal[1:0]) | istatSet;
      end else begin
        istatQ <= istatQ | istatSet;
      end
    end
  end

  assign irq = |(istatQ & imaskQ);

  always_comb begin
    rdMux = 32'h0;
    rdOk = 1'b1;
    case (araddr)
      `REG_CMD: rdMux[5:0] = cmdQ;
      `REG_ADDR: rdMux[11:0] = addrQ;
      `REG_WDATA: rdMux[7:0] = wdataQ;
      `REG_RDATA: rdMux[7:0] = rdataQ;
      `REG_STATUS: rdMux[8:0] = {link.irqLine, link.dmaRequest,
                                 stateQ != S_IDLE};
      `REG_ISTAT: rdMux[1:0] = istatQ;
      `REG_IMASK: rdMux[1:0] = imaskQ;
      `REG_PINS: rdMux[1:0] = pinsQ;
      default: rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata <= rdMux;
      rresp <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // Bus cycle sequencer
  // ************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stateQ <= S_IDLE;
      cntQ <= 3'h0;
      rdataQ <= 8'h00;
    end else begin
      case (stateQ)
        S_IDLE: begin
          if (cmdQ[`CMD_GO]) begin
            stateQ <= S_SETUP;
            cntQ <= 3'(`SETUP_CYC);
          end
        end
        S_SETUP: begin
          cntQ <= cntQ - 3'h1;
          if (cntQ == 3'h1) begin
            stateQ <= S_STROBE;
            cntQ <= 3'(`STROBE_CYC);
          end
        end
        S_STROBE: begin
          cntQ <= cntQ - 3'h1;
          if (cntQ == 3'h1) begin
            stateQ <= S_RECOVER;
            rdataQ <= link.dataBus;
          end
        end
        S_RECOVER: stateQ <= S_IDLE;
        default: stateQ <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      link.iorN <= 1'b1;
      link.iowN <= 1'b1;
      link.aen <= 1'b0;
      link.addr <= '0;
      link.dmaAckN <= '1;
      link.tc <= 1'b0;
      link.hostData <= 8'h00;
      link.hostDataOe <= 1'b0;
    end else begin
      link.addr <= addrQ[`ISA_ADDR_W-1:0];
      link.hostData <= wdataQ;
      link.tc <= (stateQ != S_IDLE) & cmdQ[`CMD_TC];
      link.aen <= (stateQ == S_SETUP || stateQ == S_STROBE)
                & (addrQ[`ADDR_AEN] | cmdQ[`CMD_DMA]);
      link.hostDataOe <= (stateQ == S_SETUP || stateQ == S_STROBE)
                       & ~cmdQ[`CMD_READ];
      link.iorN <= ~(stateQ == S_SETUP && cntQ == 3'h1 && cmdQ[`CMD_READ])
                 & ~(stateQ == S_STROBE && cntQ != 3'h1 && cmdQ[`CMD_READ]);
      link.iowN <= ~(stateQ == S_SETUP && cntQ == 3'h1 && !cmdQ[`CMD_READ])
                 & ~(stateQ == S_STROBE && cntQ != 3'h1 && !cmdQ[`CMD_READ]);
      for (int c = 0; c < `ISA_DMA_CHANNELS; c++) begin
        link.dmaAckN[c] <= ~((stateQ == S_SETUP || stateQ == S_STROBE)
          & cmdQ[`CMD_DMA] & (cmdQ[`CMD_CHAN_LSB +: 2] == 2'(c)));
      end
    end
  end

  // ************************************************************
  // Pins: qualify level and stretched hardware reset
  // ************************************************************
  logic [7:0] holdQ;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      holdQ <= 8'h00;
      link.hwReset <= 1'b0;
      link.upperAddressQualifyN <= 1'b1;
    end else begin
      if (pinsQ[`PINS_RESET]) begin
        holdQ <= 8'(`RESET_HOLD_CYC);
      end else if (holdQ != 8'h00) begin
        holdQ <= holdQ - 8'h01;
      end
      link.hwReset <= pinsQ[`PINS_RESET] | (holdQ != 8'h00);
      link.upperAddressQualifyN <= pinsQ[`PINS_QUALIFY];
    end
  end
endmodule

//--- isa_link_props.sv
// Purpose: Pin checks on the device end of the ISA link
// Assumes: Link pins change only just after mclk rising edges
// Notes: Sees interface signals only; config ports are not visible
`timescale 1ns/100ps
`include "isa_link_params.svh"
module isa_link_props (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic iorN,
  input wire logic aen,
  input wire logic hwReset,
  input wire logic [`ISA_DMA_CHANNELS-1:0] dmaAckN,
  input wire logic [`ISA_DMA_CHANNELS-1:0] dmaRequest,
  input wire isa_link_pkg::byte_t devData,
  input wire logic devDataOe
);
  import isa_link_pkg::*;
  logic ackAny;
  logic reqAny;
  assign ackAny = ~&dmaAckN;
  assign reqAny = |dmaRequest;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ************************************************************
  // Data bus and requests
  // ************************************************************
  chk_oe_in_read: assert property (devDataOe |-> !iorN)
    else $error("data bus driven outside a read");
  chk_oe_after_fall: assert property (devDataOe |-> !$past(iorN))
    else $error("data bus driven before the strobe was seen");
  chk_aen_silent: assert property
    ($fell(iorN) && aen && !ackAny |=> !devDataOe)
    else $error("read answered during an address-enable cycle");
  chk_data_hold: assert property
    (devDataOe && $past(devDataOe) |-> $stable(devData))
    else $error("read data changed while driven");
  chk_oe_release: assert property ($rose(iorN) |-> !devDataOe)
    else $error("data bus still driven after the strobe");
  chk_one_request: assert property ($onehot0(dmaRequest))
    else $error("more than one request raised");
  // A request may only drop after an acknowledge or a hardware reset
  chk_req_cause: assert property
    ($fell(reqAny) |-> $past(ackAny) || $past(hwReset))
    else $error("request dropped without a clearing cause");
  chk_tc_ignored: assert property
    (reqAny && !ackAny && !hwReset |=> reqAny)
    else $error("request cleared while no acknowledge was low");
endmodule

//--- test_isa_host_bus_interface.sv
// Purpose: Self-checking bench joining both ends of the ISA link
// Assumes: Controller registers reached over AXI4-Lite at 100 MHz
// Notes: Each scenario drives the controller and judges the results
`timescale 1ns/100ps
`include "isa_link_params.svh"
module test_isa_host_bus_interface;
  import isa_link_pkg::*;
  localparam addr_t Base = 11'h3F0;
  logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic qualifyEnable, pulsedIrqMode, dmaStart, extIrq, tcSeen, dmaBusy;
  tc_mode_e tcMode;
  logic [1:0] dmaChannel;
  logic [15:0] dmaLength;
  logic [2:0] funcIrq;
  logic [11:0] irqRoute;
  logic [63:0] regImage;
  int errors, n_checks;
  isa_link_if isa_link_if_inst();
  isa_host_end isa_host_end_inst (.mclk(mclk), .nrst(nrst),
    .link(isa_link_if_inst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
  isa_device_end isa_device_end_inst (.mclk(mclk), .nrst(nrst),
    .link(isa_link_if_inst), .baseAddr(Base), .qualifyEnable(qualifyEnable),
    .tcMode(tcMode), .pulsedIrqMode(pulsedIrqMode), .dmaChannel(dmaChannel),
    .dmaStart(dmaStart), .dmaLength(dmaLength), .funcIrq(funcIrq),
    .externalInterruptInput(extIrq), .irqRoute(irqRoute),
    .regImage(regImage), .writeData(), .writeStb(), .writeFromDma(),
    .dmaBusy(dmaBusy), .tcSeen(tcSeen), .functionalReset());
  isa_link_props isa_link_props_inst (.mclk(mclk), .nrst(nrst),
    .iorN(isa_link_if_inst.iorN), .aen(isa_link_if_inst.aen),
    .hwReset(isa_link_if_inst.hwReset), .dmaAckN(isa_link_if_inst.dmaAckN),
    .dmaRequest(isa_link_if_inst.dmaRequest),
    .devData(isa_link_if_inst.devData), .devDataOe(isa_link_if_inst.devDataOe));
  // ************************************************************
  // Bus tasks
  // ************************************************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, g, e);
    end
  endtask
  task test_done;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Sampled at the falling edge so design updates at the rising edge land
  task waitHi(input int s);
    int k;
    k = 0;
    @(negedge mclk);
    while ((s == 0 ? awready : s == 1 ? bvalid : s == 2 ? arready : rvalid)
           !== 1'b1) begin
      k++;
      if (k > 100) begin
        errors++;
        test_done();
      end
      @(negedge mclk);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    waitHi(0);
    @(posedge mclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    waitHi(1);
    resp = bresp;
    @(posedge mclk);
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    waitHi(2);
    @(posedge mclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    waitHi(3);
    d = rdata;
    resp = rresp;
    @(posedge mclk);
    rready <= 1'b0;
  endtask
  task cyc(input addr_t a, input logic e, input logic [5:0] c, input byte_t w);
    int k;
    wr(`REG_WDATA, {24'h0, w});
    wr(`REG_ADDR, {20'h0, e, a});
    wr(`REG_CMD, {26'h0, c});
    for (k = 0; k < 20; k++) begin
      rd(`REG_STATUS);
      if (d[0] === 1'b0) break;
    end
    if (k == 20) begin
      errors++;
      test_done();
    end
    rd(`REG_RDATA);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_io;
    cyc(Base + 11'h3, 1'b0, 6'h01, 8'h5A);
    chk(32'(regImage[31:24]), 32'h5A);
    cyc(Base + 11'h3, 1'b0, 6'h03, 8'h00);
    chk(d, 32'h5A);
    cyc(Base + 11'h403, 1'b0, 6'h03, 8'h00);
    chk(d, 32'hFF);
    cyc(Base + 11'h403, 1'b0, 6'h01, 8'hA5);
    chk(32'(regImage[31:24]), 32'h5A);
    cyc(Base + 11'h8, 1'b0, 6'h03, 8'h00);
    chk(d, 32'hFF);
    cyc(Base + 11'h3, 1'b1, 6'h03, 8'h00);
    chk(d, 32'hFF);
    cyc(Base + 11'h3, 1'b1, 6'h01, 8'h11);
    chk(32'(regImage[31:24]), 32'h5A);
    qualifyEnable <= 1'b1;
    cyc(Base + 11'h3, 1'b0, 6'h03, 8'h00);
    chk(d, 32'hFF);
    wr(`REG_PINS, 32'h0);
    cyc(Base + 11'h3, 1'b0, 6'h03, 8'h00);
    chk(d, 32'h5A);
    wr(`REG_PINS, 32'h1);
    qualifyEnable <= 1'b0;
    cyc(Base, 1'b0, 6'h01, 8'hC3);
    $display("t_io done");
  endtask
  task t_dma;
    int m;
    byte_t cur;
    cur = 8'hC3;
    for (m = 0; m < 3; m++) begin
      tcMode <= tc_mode_e'(m);
      dmaChannel <= 2'(m);
      dmaLength <= 16'h3;
      dmaStart <= 1'b1;
      @(posedge mclk);
      dmaStart <= 1'b0;
      rd(`REG_STATUS);
      chk(32'(d[3:1]), 32'(1 << m));
      cyc(11'h0, 1'b1, {1'(m == 2), 2'(m), 3'h7}, 8'h00);
      chk(d, 32'(cur));
      chk(32'({tcSeen, dmaBusy}), 32'h1);
      chk(32'(isa_link_if_inst.dmaRequest), 32'(1 << m));
      cur = 8'h10 + 8'(m);
      cyc(11'h0, 1'b1, {1'(m != 2), 2'(m), 3'h5}, cur);
      chk(32'(regImage[7:0]), 32'(cur));
      chk(32'({tcSeen, dmaBusy, isa_link_if_inst.dmaRequest}), 32'h10);
    end
    tcMode <= TC_HIGH_AT;
    dmaChannel <= 2'h0;
    dmaLength <= 16'h1;
    dmaStart <= 1'b1;
    @(posedge mclk);
    dmaStart <= 1'b0;
    cyc(11'h0, 1'b1, 6'h07, 8'h00);
    chk(32'({tcSeen, dmaBusy, isa_link_if_inst.dmaRequest}), 32'h0);
    $display("t_dma done");
  endtask
  task t_irq;
    int k;
    for (k = 0; k < 4; k++) begin
      {extIrq, funcIrq} <= 4'(1 << k);
      irqRoute <= (12'hFFF & ~(12'h7 << (3 * k))) | (12'(k + 1) << (3 * k));
      repeat (3) @(posedge mclk);
      rd(`REG_STATUS);
      chk(32'(d[8:4]), 32'(2 << k));
    end
    {extIrq, funcIrq} <= 4'h0;
    pulsedIrqMode <= 1'b1;
    irqRoute <= 12'hFF8;
    repeat (3) @(posedge mclk);
    funcIrq <= 3'h1;
    k = 0;
    repeat (30) begin
      @(posedge mclk);
      if (isa_link_if_inst.irqLine[0] === 1'b0) k++;
    end
    chk(32'(k), 32'(`IRQ_PULSE_CYC));
    funcIrq <= 3'h0;
    pulsedIrqMode <= 1'b0;
    $display("t_irq done");
  endtask
  task t_status;
    int k;
    rd(8'h40);
    chk(32'(resp), 32'(`RESP_SLVERR));
    wr(8'h42, 32'h0);
    chk(32'(resp), 32'(`RESP_SLVERR));
    wr(`REG_IMASK, 32'h1);
    wr(`REG_ISTAT, 32'h3);
    cyc(Base, 1'b0, 6'h03, 8'h00);
    chk(32'(irq), 32'h1);
    wr(`REG_ISTAT, 32'h1);
    chk(32'(irq), 32'h0);
    wr(`REG_IMASK, 32'h0);
    cyc(Base, 1'b0, 6'h03, 8'h00);
    chk(32'(irq), 32'h0);
    wr(`REG_PINS, 32'h3);
    wr(`REG_PINS, 32'h1);
    k = 0;
    repeat (100) begin
      @(posedge mclk);
      if (isa_link_if_inst.hwReset === 1'b1) k++;
    end
    chk(32'(k >= `RESET_HOLD_CYC), 32'h1);
    chk(32'(|regImage), 32'h0);
    cyc(Base + 11'h3, 1'b0, 6'h03, 8'h00);
    chk(d, 32'h0);
    $display("t_status done");
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
    {qualifyEnable, pulsedIrqMode, dmaStart, extIrq} = 4'h0;
    {tcMode, dmaChannel, dmaLength, funcIrq} = {TC_HIGH_AT, 21'h0};
    irqRoute = 12'hFFF;
    errors = 0;
    n_checks = 0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(`REG_PINS);
    chk(d, 32'(`PINS_RESET_VAL));
    t_io();
    t_dma();
    t_irq();
    t_status();
    test_done();
  end
endmodule
